// ---- arc_reclose_seq.sv ----
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module arc_reclose_seq #(
   parameter int unsigned TICK_CYC = arc_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trip,
   input wire logic breaker_a_contact,
   input wire logic breaker_b_contact,
   input wire logic pause_input,
   input wire logic delayed_reclose,
   output logic reclose_out,
   output logic spare_output,
   output logic lockout_out,
   output logic in_progress_out
);
   import arc_pkg::*;

   logic [17:0] ctrl_reg;
   logic [7:0] t1_reg, t2_reg, t3_reg, hold_reg;
   arc_state_e state_reg;
   logic [1:0] step_reg;
   logic [CNT_W-1:0] cnt_reg, ext_reg, sp_cnt_reg;
   logic sp_run_reg, sp_arm_reg, from_lock_reg;
   logic [31:0] tick_div_reg;
   logic tick;

   wire reclose_function_en = ctrl_reg[EN_BIT];
   wire [3:0] step_en = ctrl_reg[STEP_EN_LSB +: 4];
   wire [1:0] time_scale_sel = ctrl_reg[TIME_SCALE_SEL_LSB +: 2];
   wire [2:0] pause_code = ctrl_reg[PAUSE_LSB +: 3];
   wire [1:0] scope = ctrl_reg[SCOPE_LSB +: 2];
   wire [1:0] drop_code = ctrl_reg[DROP_LSB +: 2];
   wire [1:0] pick_code = ctrl_reg[PICK_LSB +: 2];
   wire [1:0] sel_code = ctrl_reg[SEL_LSB +: 2];
   wire closed = breaker_a_contact & ~breaker_b_contact;
   wire pause_recl = (scope == SCOPE_BOTH) || (scope == SCOPE_RECL); // R15
   wire pause_reset = (scope == SCOPE_BOTH) || (scope == SCOPE_RESET); // R15

   function automatic logic [CNT_W-1:0] scaled(input logic [CNT_W-1:0] tenths,
                                              input logic [1:0] m);
      scaled = tenths << m; // R7
   endfunction

   function automatic logic [CNT_W-1:0] secs(input logic [7:0] s);
      secs = CNT_W'(s) * SEC_TENTHS;
   endfunction

   logic [CNT_W-1:0] pause_tenths;
   always_comb begin
      unique case (pause_code) // R9
         3'h0: pause_tenths = 24'h000000;
         3'h1: pause_tenths = 24'h00000a;
         3'h2: pause_tenths = 24'h000028;
         3'h3: pause_tenths = 24'h0000a0;
         3'h4: pause_tenths = 24'h000280;
         3'h5: pause_tenths = 24'h000a00;
         3'h6: pause_tenths = 24'h002800;
         3'h7: pause_tenths = 24'hffffff;
      endcase
   end
   wire [CNT_W-1:0] pause_ticks = scaled(pause_tenths, time_scale_sel);

   logic [CNT_W-1:0] pick_tenths, drop_tenths;
   always_comb begin
      unique case (pick_code) // R18
         2'h0: pick_tenths = 24'h000000;
         2'h1: pick_tenths = 24'h00000a;
         2'h2: pick_tenths = 24'h000014;
         2'h3: pick_tenths = 24'h000028;
      endcase
      unique case (drop_code) // R16
         2'h0: drop_tenths = 24'h00003c;
         2'h1: drop_tenths = 24'h000078;
         2'h2: drop_tenths = 24'h0000f0;
         2'h3: drop_tenths = 24'hffffff;
      endcase
   end

   function automatic logic [CNT_W-1:0] step_delay(input logic [1:0] s,
         input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
         input logic [1:0] m);
      unique case (s)
         2'h0: step_delay = 24'h000000; // R2
         2'h1: step_delay = scaled(CNT_W'(a), m); // R4
         2'h2: step_delay = scaled(secs(b), m); // R5
         2'h3: step_delay = scaled(secs(c), m); // R5
      endcase
   endfunction

   // next enabled step at or after a start point, in fixed order
   logic found;
   logic [1:0] next_step;
   logic [2:0] search_from;
   always_comb begin
      found = 1'b0;
      next_step = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (step_en[i] && (3'(i) >= search_from)) begin // R21
            found = 1'b1;
            next_step = 2'(i);
         end
      end
   end
   always_comb begin
      if (state_reg == ARC_HOLD) begin
         search_from = 3'(step_reg) + 3'h1;
      end else if (delayed_reclose) begin
         search_from = 3'h1;
      end else begin
         search_from = 3'h0;
      end
   end

   // common 0.05 s time base
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_div_reg <= 32'h0;
      end else if (tick_div_reg == TICK_CYC - 1) begin // R22
         tick_div_reg <= 32'h0;
      end else begin
         tick_div_reg <= tick_div_reg + 32'h1;
      end
   end
   assign tick = (tick_div_reg == TICK_CYC - 1);

   // apb slave, answer in the first access cycle
   wire setup = psel & ~penable;
   wire wr_acc = psel & penable & pwrite & pready;
   logic mapped;
   logic [31:0] rd_val;
   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0;
      unique case (paddr)
         CTRL_OFF: rd_val = {14'h0, ctrl_reg};
         T1_OFF: rd_val = {24'h0, t1_reg};
         T2_OFF: rd_val = {24'h0, t2_reg};
         T3_OFF: rd_val = {24'h0, t3_reg};
         HOLD_OFF: rd_val = {24'h0, hold_reg};
         STAT_OFF: rd_val = {22'h0, step_reg, state_reg, in_progress_out,
                             lockout_out, spare_output, reclose_out};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= pwrite ? 32'h0 : rd_val;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RST;
         t1_reg <= T1_RST;
         t2_reg <= T2_RST;
         t3_reg <= T3_RST;
         hold_reg <= HOLD_RST;
      end else if (wr_acc) begin
         unique case (paddr)
            CTRL_OFF: ctrl_reg <= pwdata[17:0];
            T1_OFF: t1_reg <= pwdata[7:0];
            T2_OFF: t2_reg <= pwdata[7:0];
            T3_OFF: t3_reg <= pwdata[7:0];
            HOLD_OFF: hold_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   wire [CNT_W-1:0] hold_ticks = scaled(secs(hold_reg), time_scale_sel); // R6
   wire [CNT_W-1:0] limit_ticks = scaled(LIMIT_TENTHS, time_scale_sel); // R8

   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ARC_OFF;
         step_reg <= 2'h0;
         cnt_reg <= '0;
         ext_reg <= '0;
         from_lock_reg <= 1'b0;
      end else if (!reclose_function_en) begin
         state_reg <= ARC_OFF; // R1
         cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            ARC_OFF: begin
               state_reg <= closed ? ARC_IDLE : ARC_LOCK;
            end
            ARC_IDLE: begin
               if (trip) begin
                  if (found) begin
                     state_reg <= ARC_TIMING;
                     step_reg <= next_step;
                     cnt_reg <= step_delay(next_step, t1_reg, t2_reg, t3_reg, time_scale_sel);
                  end else begin
                     state_reg <= ARC_LOCK;
                  end
               end
            end
            ARC_TIMING: begin
               if (cnt_reg == '0) begin
                  if (!pause_recl || pause_input) begin // R11
                     state_reg <= ARC_CLOSE;
                     cnt_reg <= limit_ticks;
                  end else begin
                     state_reg <= ARC_PAUSE; // R10
                     cnt_reg <= pause_ticks;
                  end
               end else if (tick) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ARC_PAUSE: begin
               if (pause_input) begin
                  state_reg <= ARC_CLOSE; // R11
                  cnt_reg <= limit_ticks;
               end else if (pause_code == PAUSE_INF) begin
                  cnt_reg <= cnt_reg; // R12
               end else if (cnt_reg == '0) begin
                  state_reg <= ARC_LOCK; // R11
               end else if (tick) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ARC_CLOSE: begin
               if (closed) begin
                  state_reg <= ARC_HOLD;
                  from_lock_reg <= 1'b0;
                  cnt_reg <= hold_ticks;
                  ext_reg <= '0;
               end else if (cnt_reg == '0) begin
                  state_reg <= ARC_LOCK; // R8
               end else if (tick) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ARC_HOLD: begin
               if (trip) begin
                  if (found && !from_lock_reg) begin // R21
                     state_reg <= ARC_TIMING;
                     step_reg <= next_step;
                     cnt_reg <= step_delay(next_step, t1_reg, t2_reg, t3_reg, time_scale_sel);
                  end else begin
                     state_reg <= ARC_LOCK;
                  end
               end else if (!closed) begin
                  state_reg <= from_lock_reg ? ARC_LOCK : state_reg; // R6
               end else if (cnt_reg == '0) begin
                  state_reg <= ARC_IDLE; // R6
               end else if (tick) begin
                  if (pause_reset && !pause_input && ext_reg < pause_ticks) begin
                     ext_reg <= ext_reg + 1'b1; // R14
                  end else begin
                     cnt_reg <= cnt_reg - 1'b1; // R13
                  end
               end
            end
            ARC_LOCK: begin
               if (closed && !trip) begin
                  state_reg <= ARC_HOLD; // R6
                  from_lock_reg <= 1'b1;
                  cnt_reg <= hold_ticks;
                  ext_reg <= '0;
               end
            end
            default: state_reg <= ARC_LOCK;
         endcase
      end
   end

   // spare output timing
   wire step_fire = (state_reg != ARC_CLOSE) && (state_reg != ARC_OFF) && reclose_function_en
                    && (((state_reg == ARC_TIMING) && (cnt_reg == '0)
                         && (!pause_recl || pause_input))
                        || ((state_reg == ARC_PAUSE) && pause_input));
   wire skip_start = (state_reg == ARC_IDLE) && reclose_function_en && trip && delayed_reclose
                     && (sel_code == 2'h0);
   wire going_lock = (state_reg == ARC_LOCK) || !reclose_function_en;
   wire [CNT_W-1:0] pick_ticks = scaled(pick_tenths, time_scale_sel);
   wire [CNT_W-1:0] drop_ticks = scaled(drop_tenths, time_scale_sel);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_run_reg <= 1'b0;
         sp_arm_reg <= 1'b0;
         sp_cnt_reg <= '0;
      end else if (going_lock) begin
         sp_run_reg <= 1'b0; // R17
         sp_arm_reg <= 1'b0;
      end else if (step_fire && step_reg == sel_code) begin
         sp_run_reg <= 1'b1; // R19
         sp_cnt_reg <= '0;
      end else if (skip_start) begin
         sp_arm_reg <= 1'b1; // R20
      end else if (sp_arm_reg && breaker_b_contact) begin
         sp_arm_reg <= 1'b0; // R20
         sp_run_reg <= 1'b1;
         sp_cnt_reg <= '0;
      end else if (sp_run_reg && tick && sp_cnt_reg != {CNT_W{1'b1}}) begin
         sp_cnt_reg <= sp_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spare_output <= 1'b0;
         reclose_out <= 1'b0;
         lockout_out <= 1'b0;
         in_progress_out <= 1'b0;
      end else begin
         spare_output <= sp_run_reg && !going_lock && (sp_cnt_reg >= pick_ticks)
                         && ((drop_code == DROP_HOLD) || (sp_cnt_reg < drop_ticks)); // R16
         reclose_out <= reclose_function_en && (state_reg == ARC_CLOSE) && !closed && (cnt_reg != '0);
         lockout_out <= reclose_function_en && (state_reg == ARC_LOCK
                                   || (state_reg == ARC_HOLD && from_lock_reg));
         in_progress_out <= reclose_function_en && (state_reg == ARC_TIMING || state_reg == ARC_PAUSE
                                       || state_reg == ARC_CLOSE
                                       || (state_reg == ARC_HOLD && !from_lock_reg));
      end
   end
endmodule
`default_nettype wire

// ---- arc_pkg.sv ----
// What this block does
// [R1] the whole sequencer runs only while reclose_function_en is set
// [R2] instant_step_en includes an undelayed instantaneous reclose step
// [R3] three enables include the first, second and third timed steps
// [R4] first_step_delay is 0.1 to 15.9 s before scaling
// [R5] second and third step delays are 1 to 159 s before scaling
// [R6] hold_closed_time of closed breaker resets sequence or clears lockout
// [R7] time_scale_sel codes 0..3 scale all timings by 0.5, 1, 2, 4
// [R8] lockout unless breaker closes within 0.9 s unit reclose limit
// [R9] hold-off codes 0..7 give 0,1,4,16,64,256,1024 s or infinite
// [R10] pause window starts when reclose output would normally occur
// [R11] pause present or arriving in window recloses, else lockout on expiry
// [R12] infinite pause code waits forever in reclose mode
// [R13] reset timer runs normally while pause input held present
// [R14] reset extension equals pause-open time, capped at pause time
// [R15] scope switch 1 both, 2 reset only, 3 reclose only
// [R16] spare dropout codes give 6, 12, 24 s or hold, from the step
// [R17] hold code keeps spare_output on until lockout
// [R18] spare pickup codes give 0, 1, 2 or 4 s after the step
// [R19] spare_step_sel picks instant, first, second or third step
// [R20] skipped instant step starts spare timing from breaker_b_contact
// [R21] steps run in fixed order; trip after last enabled step locks out
// [R22] all delays count a common 0.05 s tick from the clock
package arc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned TICK_NS = 50_000_000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 24;
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] T1_OFF = 8'h04;
   localparam logic [7:0] T2_OFF = 8'h08;
   localparam logic [7:0] T3_OFF = 8'h0c;
   localparam logic [7:0] HOLD_OFF = 8'h10;
   localparam logic [7:0] STAT_OFF = 8'h14;
   localparam int EN_BIT = 0;
   localparam int STEP_EN_LSB = 1;
   localparam int TIME_SCALE_SEL_LSB = 5;
   localparam int PAUSE_LSB = 7;
   localparam int SCOPE_LSB = 10;
   localparam int DROP_LSB = 12;
   localparam int PICK_LSB = 14;
   localparam int SEL_LSB = 16;
   localparam logic [17:0] CTRL_RST = 18'h00bfe;
   localparam logic [7:0] T1_RST = 8'h0a;
   localparam logic [7:0] T2_RST = 8'h0a;
   localparam logic [7:0] T3_RST = 8'h0a;
   localparam logic [7:0] HOLD_RST = 8'h0a;
   // times in tenths of a second before scaling
   localparam logic [CNT_W-1:0] LIMIT_TENTHS = 24'h000009;
   localparam logic [CNT_W-1:0] SEC_TENTHS = 24'h00000a;
   localparam logic [2:0] PAUSE_INF = 3'h7;
   localparam logic [1:0] DROP_HOLD = 2'h3;
   localparam logic [1:0] SCOPE_BOTH = 2'h1;
   localparam logic [1:0] SCOPE_RESET = 2'h2;
   localparam logic [1:0] SCOPE_RECL = 2'h3;
   typedef enum logic [2:0] {
      ARC_IDLE = 3'h0,
      ARC_TIMING = 3'h1,
      ARC_PAUSE = 3'h2,
      ARC_CLOSE = 3'h3,
      ARC_HOLD = 3'h4,
      ARC_LOCK = 3'h5,
      ARC_OFF = 3'h6
   } arc_state_e;
endpackage

// ---- arc_reclose_seq_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module arc_reclose_seq_checker
   import arc_pkg::*;
#(
   parameter int unsigned TICK_CYC = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic breaker_a_contact,
   input wire logic breaker_b_contact,
   input wire logic reclose_out,
   input wire logic spare_output,
   input wire logic lockout_out,
   input wire logic in_progress_out
);
   logic en_q;
   logic [1:0] time_scale_sel_q;
   logic [31:0] rcnt;
   logic [31:0] lim;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // longest reclose command: scaled limit plus one tick of phase
   assign lim = ((32'(LIMIT_TENTHS) << time_scale_sel_q) * TICK_CYC) + TICK_CYC + 32'h4;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         time_scale_sel_q <= CTRL_RST[TIME_SCALE_SEL_LSB+:2];
      end else if (psel && penable && pready && pwrite && paddr == CTRL_OFF) begin
         en_q <= pwdata[EN_BIT];
         time_scale_sel_q <= pwdata[TIME_SCALE_SEL_LSB+:2];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcnt <= 32'h0;
      end else begin
         rcnt <= reclose_out ? rcnt + 32'h1 : 32'h0;
      end
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence close_s;
      $rose(breaker_a_contact) && !breaker_b_contact;
   endsequence
   ready_next_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_flag_a: assert property (pready |-> pslverr == ((paddr > STAT_OFF) || (paddr[1:0] != 2'h0)))
      else $error("error flag wrong for address");
   err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   off_quiet_a: assert property (
      !en_q [*4] |-> !(reclose_out || spare_output || lockout_out || in_progress_out))
      else $error("outputs active while disabled");
   close_drop_a: assert property (reclose_out ##0 close_s |-> ##[1:3] !reclose_out)
      else $error("reclose held after breaker closed");
   limit_bound_a: assert property (reclose_out |-> rcnt <= lim)
      else $error("reclose longer than scaled limit");
   limit_lock_a: assert property (
      en_q && $fell(reclose_out) && !breaker_a_contact |-> ##[0:3] lockout_out)
      else $error("no lockout after failed close");
   spare_clear_a: assert property ($rose(lockout_out) |-> ##[0:3] !spare_output)
      else $error("spare still on in lockout");
   lock_excl_a: assert property (lockout_out |-> !reclose_out)
      else $error("reclose while locked out");
endmodule
bind arc_reclose_seq arc_reclose_seq_checker #(.TICK_CYC(TICK_CYC)) chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .breaker_a_contact(breaker_a_contact), .breaker_b_contact(breaker_b_contact),
   .reclose_out(reclose_out), .spare_output(spare_output), .lockout_out(lockout_out),
   .in_progress_out(in_progress_out));
`default_nettype wire

// ---- arc_breaker_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module arc_breaker_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic trip,
   input wire logic reclose_out,
   input wire logic manual_close,
   input wire logic stuck,
   input wire logic [3:0] lag,
   output logic breaker_a_contact,
   output logic breaker_b_contact
);
   logic [3:0] cnt;
   // opens on trip, closes after lag+1 cycles of reclose unless stuck
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         breaker_a_contact <= 1'b1;
         cnt <= 4'h0;
      end else if (trip) begin
         breaker_a_contact <= 1'b0;
      end else if (manual_close) begin
         breaker_a_contact <= 1'b1;
      end else if (reclose_out && !stuck) begin
         cnt <= cnt + 4'h1;
         if (cnt == lag) begin
            breaker_a_contact <= 1'b1;
         end
      end else begin
         cnt <= 4'h0;
      end
   end
   assign breaker_b_contact = !breaker_a_contact;
endmodule
`default_nettype wire

// ---- arc_reclose_seq_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module arc_reclose_seq_tb;
   import arc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic trip = 1'b0, pause_input = 1'b0, man = 1'b0, stuck = 1'b0, dly = 1'b0;
   logic [3:0] lag = 4'h3;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, v, seed;
   logic pready, pslverr, bra, brb, rec, spare, lock, busy;
   logic [32:0] exp_q[$];
   logic [32:0] msk_q[$];
   int error_cnt = 0, checks_done = 0, n;
   arc_reclose_seq #(.TICK_CYC(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trip(trip), .breaker_a_contact(bra),
      .breaker_b_contact(brb), .pause_input(pause_input), .delayed_reclose(dly),
      .reclose_out(rec), .spare_output(spare), .lockout_out(lock), .in_progress_out(busy));
   arc_breaker_model brk (.pclk(pclk), .presetn(presetn), .trip(trip), .reclose_out(rec),
      .manual_close(man), .stuck(stuck), .lag(lag), .breaker_a_contact(bra),
      .breaker_b_contact(brb));
   always #25 pclk = ~pclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      checks_done++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask
   // read results compared against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   task automatic wait_rec(input int lim);
      n = 0;
      while (rec !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic fault();
      trip <= 1'b1;
      repeat (2) @(posedge pclk);
      trip <= 1'b0;
   endtask
   task automatic recover();
      man <= 1'b1;
      @(posedge pclk);
      man <= 1'b0;
      repeat (60) @(posedge pclk);
      check(33'(lock), 33'h1);
      repeat (100) @(posedge pclk);
      check(33'(lock), 33'h0);
   endtask
   initial begin
      seed = 32'h00009642;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(CTRL_OFF, 33'(CTRL_RST), '1);
      for (int i = 1; i < 5; i++) begin
         rd(8'(4 * i), 33'(T1_RST), '1);
      end
      rd(8'h18, {1'b1, 32'h0}, '1);
      seed = xs(seed);
      v = seed % 32'h9f + 32'h1;
      apb(1'b1, T1_OFF, v);
      rd(T1_OFF, 33'(v), '1);
      apb(1'b1, T1_OFF, 32'h2);
      apb(1'b1, HOLD_OFF, 32'h1);
      apb(1'b1, CTRL_OFF, 32'h3007);
      repeat (5) @(posedge pclk);
      rd(STAT_OFF, 33'h0, 33'h7f);
      fault();
      wait_rec(60);
      check(33'(n < 15), 33'h1);
      repeat (5) @(posedge pclk);
      check(33'(spare), 33'h1);
      repeat (30) @(posedge pclk);
      fault();
      wait_rec(200);
      check(33'(n > 14 && n < 35), 33'h1);
      check(33'(spare), 33'h1);
      repeat (30) @(posedge pclk);
      fault();
      repeat (8) @(posedge pclk);
      check({31'h0, lock, spare}, 33'h2);
      rd(STAT_OFF, 33'h54, 33'h77);
      recover();
      stuck <= 1'b1;
      fault();
      wait_rec(60);
      repeat (75) @(posedge pclk);
      check({31'h0, rec, lock}, 33'h2);
      repeat (35) @(posedge pclk);
      check({31'h0, rec, lock}, 33'h1);
      stuck <= 1'b0;
      recover();
      apb(1'b1, CTRL_OFF, 32'h3c07);
      fault();
      wait_rec(40);
      check({31'h0, rec, lock}, 33'h1);
      recover();
      check(33'(spare), 33'h0);
      dly <= 1'b1;
      fault();
      repeat (5) @(posedge pclk);
      check({31'h0, rec, spare}, 33'h1);
      dly <= 1'b0;
      repeat (40) @(posedge pclk);
      check({31'h0, lock, spare}, 33'h2);
      recover();
      apb(1'b1, CTRL_OFF, 32'h3c87);
      lag <= 4'hc;
      fault();
      repeat (30) @(posedge pclk);
      check({31'h0, rec, lock}, 33'h0);
      pause_input <= 1'b1;
      wait_rec(10);
      check(33'(n < 10), 33'h1);
      repeat (20) @(posedge pclk);
      apb(1'b1, CTRL_OFF, 32'h0);
      repeat (4) @(posedge pclk);
      rd(STAT_OFF, 33'h60, 33'h7f);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire
